// >>> hdl/bus_timeout_map.vh
// Summary of operation
// (RULE_01) The cache-present bit 5 of system_configuration reads 0 while the instruction cache is not working and 1 while it is enabled and working.
// (RULE_02) Software writing system_configuration always writes zero into reserved bit 4, which is readable and writable.
// (RULE_03) Bits 15-6 of system_configuration read the fixed pattern 1000001000 and bits 3-0 read zero; neither can be written.
// (RULE_04) With the peripheral time-out enabled, a CPU or DMA access to a disabled or idle peripheral left unacknowledged for 512 cycles returns a time-out error to that master.
// (RULE_05) A time-out error seen by the CPU becomes a CPU bus error that raises the bus error interrupt.
// (RULE_06) A time-out error returned to the DMA controller sets its time-out status flag and signals an error that the CPU can service.
// (RULE_07) Bit 1 of timeout_control, read/write and reset to 0, enables a time-out error for an external memory access stalled 512 cycles.
// (RULE_08) Bit 0 of timeout_control, read/write and reset to 1, enables time-out errors for stalled accesses to disabled or idle peripherals.
// (RULE_09) Software should leave the external memory time-out disabled because it may cause unexpected results.
// (RULE_10) A time-out during a peripheral register access sets the peripheral time-out flag at bit 12 of the expansion-port error register.
// (RULE_11) A time-out of any access to external memory sets the external memory time-out flag at bit 12 of the data-port error register.
// (RULE_12) The peripheral time-out enable is bit 0 of timeout_control, and a stall counter clears whenever its access is acknowledged.
`ifndef BUS_TIMEOUT_MAP_VH
`define BUS_TIMEOUT_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_SYS_CONFIG      16'h07FD
`define IDX_TIMEOUT_CTRL    16'h9000
`define IDX_XPORT_ERR       16'h0102
`define IDX_DPORT_ERR       16'h0202
`define IDX_IRQ_STATUS      16'h9001
`define IDX_IRQ_MASK        16'h9002

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CFG_FIXED_PATTERN   10'h208
`define CFG_FIXED_LSB       6
`define CFG_INSTRUCTION_CACHE_BIT      5
`define CFG_RSVD_RW_BIT     4
`define CFG_RSVD_RW_RESET   1'b0
`define TOC_PERIPH_EN_BIT   0
`define TOC_EXTMEM_EN_BIT   1
`define TOC_PERIPH_EN_RESET 1'b1
`define TOC_EXTMEM_EN_RESET 1'b0
`define ERR_FLAG_BIT        12

// irq status / mask bit layout
`define IRQ_W               4
`define IRQ_CPU_BUS_ERROR_IRQ        0
`define IRQ_DMA_TIMEOUT     1
`define IRQ_PERIPH_TO       2
`define IRQ_EXTMEM_TO       3
`define IRQ_MASK_RESET      4'h0

// external memory requester codes
`define MST_CPU             2'h0
`define MST_DMA             2'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TIMEOUT_CYCLES      512
`define TIMEOUT_CNT_W       10

`endif

// >>> hdl/stall_counter.v
`timescale 1ns/1ns
`default_nettype none

// counts stalled cycles of one access, fires once at the limit
module stall_counter #(
    parameter LIMIT = 512,
    parameter CW    = 10
) (
    // clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // access state
    input  wire en_i,
    input  wire req_i,
    input  wire ack_i,
    // one-cycle time-out pulse
    output reg  fire_o
);

    // last count index, cut to the counter width on purpose
    localparam integer  LAST_I = LIMIT - 1;
    localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

    reg [CW-1:0] cnt;
    reg          done;

    // clear on ack, idle or disable; single fire per stalled access
    always @(posedge clk_i) begin
        if (rst_i || !en_i || !req_i || ack_i) begin
            cnt    <= {CW{1'b0}}; // RULE_12
            done   <= 1'b0;
            fire_o <= 1'b0;
        end else if (!done) begin
            if (cnt == LAST) begin
                fire_o <= 1'b1; // RULE_04
                done   <= 1'b1;
            end else begin
                cnt    <= cnt + 1'b1;
                fire_o <= 1'b0;
            end
        end else begin
            fire_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/event_flags.v
`timescale 1ns/1ns
`default_nettype none

// sticky event bits, write-one-to-clear, set wins over clear
module event_flags #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // events and clears
    input  wire [W-1:0] set_i,
    input  wire [W-1:0] clr_i,
    // sticky state
    output reg  [W-1:0] flags_o
);

    // set has priority so no event is lost in the clearing cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= {W{1'b0}};
        end else begin
            flags_o <= (flags_o & ~clr_i) | set_i;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/bus_timeout_and_sys_config.v
`timescale 1ns/1ns
`default_nettype none
`include "bus_timeout_map.vh"

module bus_timeout_and_sys_config #(
    parameter LIMIT = `TIMEOUT_CYCLES,
    parameter CW    = `TIMEOUT_CNT_W
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [17:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // instruction cache state
    input  wire        instruction_cache_working_i,
    // cpu access to disabled or idle peripheral
    input  wire        cpu_periph_req_i,
    input  wire        cpu_periph_ack_i,
    // dma access to disabled or idle peripheral
    input  wire        dma_periph_req_i,
    input  wire        dma_periph_ack_i,
    // access through external memory interface
    input  wire        ext_mem_req_i,
    input  wire        ext_mem_ack_i,
    input  wire [1:0]  ext_mem_master_i,
    // time-out errors toward masters
    output reg         cpu_timeout_err_o,
    output reg         dma_timeout_err_o,
    output reg         ext_mem_timeout_err_o,
    // interrupts
    output reg         bus_error_irq_o,
    output reg         irq_o
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    localparam [5:0] SEL_CFG  = 6'h01;
    localparam [5:0] SEL_TOC  = 6'h02;
    localparam [5:0] SEL_EXPANSION_PORT_ERROR_REG = 6'h04;
    localparam [5:0] SEL_DATA_PORT_ERROR_REG = 6'h08;
    localparam [5:0] SEL_STAT = 6'h10;
    localparam [5:0] SEL_MASK = 6'h20;
    localparam [5:0] SEL_NONE = 6'h00;

    // one-hot register select from a word index
    function [5:0] reg_sel;
        input [15:0] idx;
        begin
            case (idx)
                `IDX_SYS_CONFIG:   reg_sel = SEL_CFG;
                `IDX_TIMEOUT_CTRL: reg_sel = SEL_TOC;
                `IDX_XPORT_ERR:    reg_sel = SEL_EXPANSION_PORT_ERROR_REG;
                `IDX_DPORT_ERR:    reg_sel = SEL_DATA_PORT_ERROR_REG;
                `IDX_IRQ_STATUS:   reg_sel = SEL_STAT;
                `IDX_IRQ_MASK:     reg_sel = SEL_MASK;
                default:           reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    wire [5:0]  rsel   = reg_sel(adr_i[17:2]);
    wire        wr_go  = cyc_i & stb_i & we_i & ack_o;
    wire [15:0] wr_dat = dat_i[15:0];

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    reg             cfg_rsvd_bit;
    reg             instruction_cache_ok_flag;
    reg             periph_timeout_en;
    reg             ext_mem_timeout_en;
    reg [`IRQ_W-1:0] irq_mask;
    wire [`IRQ_W-1:0] irq_status;

    // writes take effect at the edge where ack is sampled
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_rsvd_bit       <= `CFG_RSVD_RW_RESET;
            periph_timeout_en  <= `TOC_PERIPH_EN_RESET; // RULE_08
            ext_mem_timeout_en <= `TOC_EXTMEM_EN_RESET; // RULE_07
            irq_mask           <= `IRQ_MASK_RESET;
        end else if (wr_go && sel_i[0]) begin
            if (rsel == SEL_CFG) begin
                cfg_rsvd_bit <= wr_dat[`CFG_RSVD_RW_BIT]; // RULE_02
            end
            if (rsel == SEL_TOC) begin
                periph_timeout_en  <= wr_dat[`TOC_PERIPH_EN_BIT]; // RULE_12
                ext_mem_timeout_en <= wr_dat[`TOC_EXTMEM_EN_BIT]; // RULE_07
            end
            if (rsel == SEL_MASK) begin
                irq_mask <= wr_dat[`IRQ_W-1:0];
            end
        end
    end

    // cache state sampled into the configuration register
    always @(posedge clk_i) begin
        if (rst_i) begin
            instruction_cache_ok_flag <= 1'b0;
        end else begin
            instruction_cache_ok_flag <= instruction_cache_working_i; // RULE_01
        end
    end

    // ----------------------------------------------------------------
    // stall monitors
    // ----------------------------------------------------------------
    wire cpu_fire;
    wire dma_fire;
    wire ext_fire;

    stall_counter #(.LIMIT(LIMIT), .CW(CW)) u_cpu_mon (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (periph_timeout_en),
        .req_i  (cpu_periph_req_i),
        .ack_i  (cpu_periph_ack_i),
        .fire_o (cpu_fire)
    );

    stall_counter #(.LIMIT(LIMIT), .CW(CW)) u_dma_mon (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (periph_timeout_en),
        .req_i  (dma_periph_req_i),
        .ack_i  (dma_periph_ack_i),
        .fire_o (dma_fire)
    );

    stall_counter #(.LIMIT(LIMIT), .CW(CW)) u_ext_mon (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (ext_mem_timeout_en),
        .req_i  (ext_mem_req_i),
        .ack_i  (ext_mem_ack_i),
        .fire_o (ext_fire)
    );

    // ext master latched while its access is pending
    reg [1:0] ext_owner;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_owner <= `MST_CPU;
        end else if (ext_mem_req_i) begin
            ext_owner <= ext_mem_master_i;
        end
    end

    wire ext_to_cpu = ext_fire & (ext_owner == `MST_CPU);
    wire ext_to_dma = ext_fire & (ext_owner == `MST_DMA);

    // error pulses to the masters
    always @(posedge clk_i) begin
        if (rst_i) begin
            cpu_timeout_err_o     <= 1'b0;
            dma_timeout_err_o     <= 1'b0;
            ext_mem_timeout_err_o <= 1'b0;
        end else begin
            cpu_timeout_err_o     <= cpu_fire | ext_to_cpu; // RULE_04
            dma_timeout_err_o     <= dma_fire | ext_to_dma; // RULE_06
            ext_mem_timeout_err_o <= ext_fire;              // RULE_07
        end
    end

    // ----------------------------------------------------------------
    // sticky flags and interrupt
    // ----------------------------------------------------------------
    reg  [`IRQ_W-1:0] ev_set;
    wire [`IRQ_W-1:0] ev_clr;

    // map monitor events onto status bits
    always @* begin
        ev_set = {`IRQ_W{1'b0}};
        ev_set[`IRQ_CPU_BUS_ERROR_IRQ]    = cpu_fire | ext_to_cpu; // RULE_05
        ev_set[`IRQ_DMA_TIMEOUT] = dma_fire | ext_to_dma; // RULE_06
        ev_set[`IRQ_PERIPH_TO]   = cpu_fire | dma_fire;   // RULE_10
        ev_set[`IRQ_EXTMEM_TO]   = ext_fire;              // RULE_11
    end

    assign ev_clr = (wr_go && sel_i[0] && rsel == SEL_STAT) ?
                    wr_dat[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

    event_flags #(.W(`IRQ_W)) u_flags (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (ev_set),
        .clr_i   (ev_clr),
        .flags_o (irq_status)
    );

    // level interrupts from unmasked status
    always @(posedge clk_i) begin
        if (rst_i) begin
            bus_error_irq_o <= 1'b0;
            irq_o           <= 1'b0;
        end else begin
            bus_error_irq_o <= irq_status[`IRQ_CPU_BUS_ERROR_IRQ] & irq_mask[`IRQ_CPU_BUS_ERROR_IRQ]; // RULE_05
            irq_o           <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read mux and acknowledge
    // ----------------------------------------------------------------
    reg [15:0] rd_word;

    always @* begin
        rd_word = 16'h0000;
        case (rsel)
            SEL_CFG: begin
                rd_word[15:`CFG_FIXED_LSB]  = `CFG_FIXED_PATTERN; // RULE_03
                rd_word[`CFG_INSTRUCTION_CACHE_BIT]    = instruction_cache_ok_flag;     // RULE_01
                rd_word[`CFG_RSVD_RW_BIT]   = cfg_rsvd_bit;
            end
            SEL_TOC: begin
                rd_word[`TOC_PERIPH_EN_BIT] = periph_timeout_en;
                rd_word[`TOC_EXTMEM_EN_BIT] = ext_mem_timeout_en;
            end
            SEL_EXPANSION_PORT_ERROR_REG: rd_word[`ERR_FLAG_BIT] = irq_status[`IRQ_PERIPH_TO]; // RULE_10
            SEL_DATA_PORT_ERROR_REG: rd_word[`ERR_FLAG_BIT] = irq_status[`IRQ_EXTMEM_TO]; // RULE_11
            SEL_STAT: rd_word[`IRQ_W-1:0]    = irq_status;
            SEL_MASK: rd_word[`IRQ_W-1:0]    = irq_mask;
            default:  rd_word = 16'h0000;
        endcase
    end

    // one-wait-state ack, unmapped addresses ack with zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (cyc_i && stb_i && !ack_o && !we_i) begin
                dat_o <= {16'h0000, rd_word};
            end
        end
    end

endmodule

`default_nettype wire

// >>> tb/bus_timeout_checker.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// port checker
// --------------------------------
module bus_timeout_checker #(
    parameter LIMIT = 512
) (
    // clock, reset and bus
    input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i,
    input wire logic [17:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic        ack_o, instruction_cache_working_i,
    // far side accesses
    input wire logic        cpu_periph_req_i, cpu_periph_ack_i,
    input wire logic        dma_periph_req_i, dma_periph_ack_i,
    input wire logic        ext_mem_req_i, ext_mem_ack_i,
    input wire logic [1:0]  ext_mem_master_i,
    // errors and interrupts
    input wire logic        cpu_timeout_err_o, dma_timeout_err_o,
    input wire logic        ext_mem_timeout_err_o, bus_error_irq_o, irq_o
);
    logic [10:0] cpu_n, dma_n, ext_n;

    // consecutive stalled edges per channel
    always @(posedge clk_i) begin
        cpu_n <= (rst_i || !cpu_periph_req_i || cpu_periph_ack_i) ? 11'h000 : cpu_n + 11'h001;
        dma_n <= (rst_i || !dma_periph_req_i || dma_periph_ack_i) ? 11'h000 : dma_n + 11'h001;
        ext_n <= (rst_i || !ext_mem_req_i || ext_mem_ack_i) ? 11'h000 : ext_n + 11'h001;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_cfg_read;
        ack_o && !we_i && adr_i[17:2] == 16'h07FD;
    endsequence

    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_latency: assert property (s_taken |=> ack_o)
        else $error("ack not one cycle after request");
    chk_cfg_fixed: assert property (s_cfg_read |-> dat_o[15:6] == 10'h208 && dat_o[3:0] == 4'h0)
        else $error("config fixed bits wrong");
    chk_cpu_err_cause: assert property (cpu_timeout_err_o |-> $past(cpu_n) >= LIMIT || $past(ext_n) >= LIMIT)
        else $error("cpu error without full stall");
    chk_dma_err_cause: assert property (dma_timeout_err_o |-> $past(dma_n) >= LIMIT || $past(ext_n) >= LIMIT)
        else $error("dma error without full stall");
    chk_ext_err_cause: assert property (ext_mem_timeout_err_o |-> $past(ext_n) >= LIMIT)
        else $error("ext error without full stall");
    chk_err_single: assert property (cpu_timeout_err_o |=> !cpu_timeout_err_o)
        else $error("cpu error pulse too long");
    chk_irq_level: assert property (bus_error_irq_o |-> irq_o)
        else $error("bus error irq without irq");
    chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o)
        else $error("outputs active after reset");
endmodule

bind bus_timeout_and_sys_config bus_timeout_checker #(.LIMIT(LIMIT)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .instruction_cache_working_i(instruction_cache_working_i),
    .cpu_periph_req_i(cpu_periph_req_i), .cpu_periph_ack_i(cpu_periph_ack_i),
    .dma_periph_req_i(dma_periph_req_i), .dma_periph_ack_i(dma_periph_ack_i),
    .ext_mem_req_i(ext_mem_req_i), .ext_mem_ack_i(ext_mem_ack_i),
    .ext_mem_master_i(ext_mem_master_i), .cpu_timeout_err_o(cpu_timeout_err_o),
    .dma_timeout_err_o(dma_timeout_err_o), .ext_mem_timeout_err_o(ext_mem_timeout_err_o),
    .bus_error_irq_o(bus_error_irq_o), .irq_o(irq_o));
`default_nettype wire

// >>> tb/far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
// one access at a time: 0 cpu, 1 dma, 2 ext memory
module far_side_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // scenario control
    input  wire logic       start_i,
    input  wire logic [1:0] sel_i,
    input  wire logic [1:0] owner_i,
    input  wire logic [7:0] ack_after_i,
    // toward the block
    output logic [2:0]      req_o,
    output logic [2:0]      ack_o,
    output logic [1:0]      master_o
);
    logic       busy, ackr;
    logic [1:0] which;
    logic [7:0] cnt;

    // request held until acked or given up
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            ackr <= 1'b0;
        end else if (start_i && !busy) begin
            busy <= 1'b1;
            cnt <= 8'h00;
            which <= sel_i;
        end else if (busy) begin
            cnt <= cnt + 8'h01;
            if (ackr) begin
                busy <= 1'b0;
                ackr <= 1'b0;
            end else if (ack_after_i != 8'h00 && cnt == ack_after_i) begin
                ackr <= 1'b1;
            end else if (cnt == 8'h14) begin
                busy <= 1'b0;
            end
        end
    end

    // idle owner lines show the inverse, not a stale value
    assign req_o = busy ? 3'b001 << which : 3'b000;
    assign ack_o = ackr ? 3'b001 << which : 3'b000;
    assign master_o = busy ? owner_i : ~owner_i;
endmodule
`default_nettype wire

// >>> tb/tb_bus_timeout_and_sys_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "bus_timeout_map.vh"
module tb_bus_timeout_and_sys_config;
    localparam LIM = 8;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, instruction_cache = 0, start = 0;
    logic [17:0] adr = 0;
    logic [31:0] dat = 0;
    logic [1:0]  psel = 0, owner = 0;
    logic [7:0]  ack_after = 0;
    logic [15:0] q;
    wire [31:0]  dat_o;
    wire         ack_o, bus_error_irq_irq, irq;
    wire [2:0]   req, pack, errs;
    wire [1:0]   mst;
    int miscompares = 0, checks = 0, cycles = 0, n;

    bus_timeout_and_sys_config #(.LIMIT(LIM), .CW(10)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .instruction_cache_working_i(instruction_cache), .cpu_periph_req_i(req[0]), .cpu_periph_ack_i(pack[0]),
        .dma_periph_req_i(req[1]), .dma_periph_ack_i(pack[1]), .ext_mem_req_i(req[2]),
        .ext_mem_ack_i(pack[2]), .ext_mem_master_i(mst), .cpu_timeout_err_o(errs[0]),
        .dma_timeout_err_o(errs[1]), .ext_mem_timeout_err_o(errs[2]),
        .bus_error_irq_o(bus_error_irq_irq), .irq_o(irq));
    far_side_model u_far (
        .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .sel_i(psel), .owner_i(owner),
        .ack_after_i(ack_after), .req_o(req), .ack_o(pack), .master_o(mst));

    initial forever #5 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test;
        end
    end

    task finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle, held until ack
    task wb(input logic w, input logic [15:0] idx, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, idx, 2'b00, 16'h0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (ack_o !== 1'b1) begin
            miscompares++;
            $display("wrong value ack expected 1 seen %b", ack_o);
        end
        q = dat_o[15:0];
        {cyc, stb} <= 2'b00;
    endtask
    task rd(input logic [15:0] idx, input logic [31:0] e, input string nm);
        wb(1'b0, idx, 16'h0000);
        chk(nm, e, {16'h0000, q});
    endtask
    // one stalled access; n = edges from first stall to error
    task stall(input logic [1:0] s, input logic [1:0] o, input logic [7:0] aa, input int b);
        @(posedge clk_i);
        {start, psel, owner, ack_after} <= {1'b1, s, o, aa};
        @(posedge clk_i);
        start <= 1'b0;
        n = 0;
        while (req[s] !== 1'b1 && n < 5) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (errs[b] !== 1'b1 && n < 30);
        if (n == LIM + 1) begin
            @(posedge clk_i);
            chk("error pulse", 0, errs[b]);
        end
        repeat (24) @(posedge clk_i);
    endtask

    task t_regs;
        rd(`IDX_SYS_CONFIG, 32'h8200, "config");
        instruction_cache <= 1'b1;
        rd(`IDX_SYS_CONFIG, 32'h8220, "config");
        wb(1'b1, `IDX_SYS_CONFIG, 16'hFFEF);
        rd(`IDX_SYS_CONFIG, 32'h8220, "config ro");
        rd(`IDX_TIMEOUT_CTRL, 32'h0001, "timeout ctrl");
        rd(16'h0055, 32'h0, "unmapped");
        $display("test regs done");
    endtask
    task t_periph;
        stall(2'd0, 2'd0, 8'h00, 0);
        chk("cpu err edges", LIM + 1, n);
        rd(`IDX_IRQ_STATUS, 32'h0005, "status");
        rd(`IDX_XPORT_ERR, 32'h1000, "xport err");
        chk("irq masked", 0, irq);
        wb(1'b1, `IDX_IRQ_MASK, 16'h000F);
        repeat (2) @(posedge clk_i);
        chk("bus err irq", 1, bus_error_irq_irq);
        wb(1'b1, `IDX_IRQ_STATUS, 16'h0005);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 0, irq);
        $display("test periph done");
    endtask
    task t_dma;
        stall(2'd1, 2'd1, 8'h00, 1);
        chk("dma err edges", LIM + 1, n);
        rd(`IDX_IRQ_STATUS, 32'h0006, "status");
        chk("dma irq", 1, irq);
        wb(1'b1, `IDX_IRQ_STATUS, 16'h0006);
        $display("test dma done");
    endtask
    task t_ack;
        stall(2'd0, 2'd0, LIM - 2, 0);
        chk("acked no err", 30, n);
        wb(1'b1, `IDX_TIMEOUT_CTRL, 16'h0000);
        stall(2'd0, 2'd0, 8'h00, 0);
        chk("disabled no err", 30, n);
        rd(`IDX_IRQ_STATUS, 32'h0, "status");
        $display("test ack done");
    endtask
    task t_ext;
        stall(2'd2, 2'd2, 8'h00, 2);
        chk("ext off", 30, n);
        wb(1'b1, `IDX_TIMEOUT_CTRL, 16'h0003);
        stall(2'd2, 2'd2, 8'h00, 2);
        chk("ext err edges", LIM + 1, n);
        rd(`IDX_DPORT_ERR, 32'h1000, "dport err");
        rd(`IDX_IRQ_STATUS, 32'h0008, "status");
        stall(2'd2, 2'd0, 8'h00, 0);
        chk("ext cpu err", LIM + 1, n);
        wb(1'b1, `IDX_TIMEOUT_CTRL, 16'h0001);
        rd(`IDX_TIMEOUT_CTRL, 32'h0001, "timeout ctrl");
        $display("test ext done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_periph;
        t_dma;
        t_ack;
        t_ext;
        finish_test;
    end
endmodule
`default_nettype wire
